// ---- rtl/bsr_consts.vh ----
// How it works
// - Large package: boundary shift register is exactly 126 bits from TDI to TDO.
// - Small package: boundary shift register is exactly 118 bits long.
// - External test captures and updates; sample only captures, pins stay functional.
// - Boundary register observes every pin and controls all but the crystal input, plus the weak pullup.
// - Bit 0 captures core reset-drive enable; update drives reset pin output enable.
// - Bit 1 captures reset pin level; its update does nothing.
// - Bits 2 and 3 are the CAN receive pin enable and data pair.
// - Bits 4 and 5 are the CAN transmit pin enable and data pair.
// - Bit 6 captures the crystal input level; update unused.
// - Bit 7 captures core weak-pullup enable; update drives port weak-pullup enable.
// - Port 0 uses bits 8 to 23, even bit enable, odd bit data.
// - Ports 1, 2, 3 start at bits 24, 40, 56 with the same pairing.
// - Port 4 pins 5, 6, 7 use bits 72 to 77, enable then data.
// - Port 5 uses bits 78 to 93 with the same pairing.
// - Port 6 follows, enable bits ending at 108, data at 109.
// - Port 7 uses bits 110 to 125, last enable 124, last data 125.
// - Instruction code 0x0000 selects the register and hands pins to the update stage.
// - Instruction code 0x0002 selects the register, pins remain under functional control.
// - During external test every input feeding core logic is forced high.
`ifndef BSR_CONSTS_VH
`define BSR_CONSTS_VH

// ============================================================
// Register length per package.
`define BSR_LEN_LARGE     126
`define BSR_LEN_SMALL     118

// ============================================================
// Instruction codes.
`define BSR_IR_WIDTH      16
`define BSR_IR_EXTEST     16'h0000
`define BSR_IR_SAMPLE     16'h0002

// ============================================================
// Bit positions in the boundary register.
`define BSR_BIT_RST_EN    0
`define BSR_BIT_RST_IN    1
`define BSR_BIT_CAN_RX    2
`define BSR_BIT_CAN_TX    4
`define BSR_BIT_XTAL      6
`define BSR_BIT_WPU       7
`define BSR_BIT_PORT0     8
`define BSR_BIT_PORT1     24
`define BSR_BIT_PORT2     40
`define BSR_BIT_PORT3     56
`define BSR_BIT_PORT4     72
`define BSR_BIT_PORT5     78
`define BSR_BIT_PORT6     94
`define BSR_BIT_PORT7     110

// ============================================================
// Port pin count (ports 0-3, port 4 pins 5-7, ports 5-7).
`define BSR_PORT_PINS     59

`endif

// ---- rtl/bsr_pin_cell.v ----
`timescale 1ns/100ps
// ============================================================
// One bidirectional pin: input synchroniser and test/functional mux.
module bsr_pin_cell
(
	input  wire clk,
	input  wire reset,
	input  wire extest,
	input  wire upd_oe,
	input  wire upd_dat,
	input  wire core_oe,
	input  wire core_out,
	input  wire pin_in,
	output reg  pin_in_s,
	output reg  pin_out_r,
	output reg  pin_oe_n_r,
	output reg  core_in_r
);

	reg pin_in_m_r;

	always @(posedge clk)
	begin
		if (reset)
		begin
			pin_in_m_r <= 1'b0;
			pin_in_s   <= 1'b0;
			pin_out_r  <= 1'b0;
			pin_oe_n_r <= 1'b1;
			core_in_r  <= 1'b1;
		end
		else
		begin
			pin_in_m_r <= pin_in;
			pin_in_s   <= pin_in_m_r;
			pin_out_r  <= extest ? upd_dat : core_out;
			pin_oe_n_r <= ~(extest ? upd_oe : core_oe);
			core_in_r  <= extest ? 1'b1 : pin_in_s;
		end
	end

endmodule

// ---- rtl/bsr_top.v ----
`timescale 1ns/100ps
`include "bsr_consts.vh"
// ============================================================
// Boundary-scan data register with capture, shift and update stages.
module bsr_top
#(
	parameter BSR_LEN   = `BSR_LEN_LARGE,
	parameter PORT_PINS = `BSR_PORT_PINS
)
(
	input  wire                 clk,
	input  wire                 reset,
	input  wire                 tck,
	input  wire                 tdi,
	output reg                  tdo_r,
	output reg                  tdo_oe_n_r,
	input  wire                 tap_capture_dr,
	input  wire                 tap_shift_dr,
	input  wire                 tap_update_dr,
	input  wire                 tap_logic_reset,
	input  wire [15:0]          tap_ir_code,
	input  wire                 core_rst_drive_en,
	input  wire                 rst_pin_in,
	output reg                  rst_pin_oe_n_r,
	output reg                  core_rst_in_r,
	input  wire                 crystal_input_pin,
	input  wire                 core_weak_pullup_en,
	output reg                  weak_pullup_en_r,
	input  wire                 can_rx_core_oe,
	input  wire                 can_rx_core_out,
	input  wire                 can_rx_pin_in,
	output wire                 can_rx_pin_out_r,
	output wire                 can_rx_pin_oe_n_r,
	output wire                 can_rx_core_in_r,
	input  wire                 can_tx_core_oe,
	input  wire                 can_tx_core_out,
	input  wire                 can_tx_pin_in,
	output wire                 can_tx_pin_out_r,
	output wire                 can_tx_pin_oe_n_r,
	output wire                 can_tx_core_in_r,
	input  wire [PORT_PINS-1:0] port_core_oe,
	input  wire [PORT_PINS-1:0] port_core_out,
	input  wire [PORT_PINS-1:0] port_pin_in,
	output wire [PORT_PINS-1:0] port_pin_out_r,
	output wire [PORT_PINS-1:0] port_pin_oe_n_r,
	output wire [PORT_PINS-1:0] port_core_in_r,
	output reg                  extest_active_r
);

	localparam FULL = `BSR_LEN_LARGE;

	// ============================================================
	// Synchronisers for the test clock side signals and for the reset and crystal pins.
	reg        tck_m_r, tck_s_r, tck_d_r;
	reg        tdi_m_r, tdi_s_r;
	reg  [3:0] st_m_r, st_s_r;
	reg [15:0] ir_m_r, ir_s_r;
	reg        rst_in_m_r, rst_in_s_r;
	reg        xtal_m_r, xtal_s_r;

	always @(posedge clk)
	begin
		if (reset)
		begin
			tck_m_r    <= 1'b0;
			tck_s_r    <= 1'b0;
			tck_d_r    <= 1'b0;
			tdi_m_r    <= 1'b0;
			tdi_s_r    <= 1'b0;
			st_m_r     <= 4'h0;
			st_s_r     <= 4'h0;
			ir_m_r     <= 16'hffff;
			ir_s_r     <= 16'hffff;
			rst_in_m_r <= 1'b1;
			rst_in_s_r <= 1'b1;
			xtal_m_r   <= 1'b0;
			xtal_s_r   <= 1'b0;
		end
		else
		begin
			tck_m_r    <= tck;
			tck_s_r    <= tck_m_r;
			tck_d_r    <= tck_s_r;
			tdi_m_r    <= tdi;
			tdi_s_r    <= tdi_m_r;
			st_m_r     <= {tap_logic_reset, tap_update_dr, tap_shift_dr, tap_capture_dr};
			st_s_r     <= st_m_r;
			ir_m_r     <= tap_ir_code;
			ir_s_r     <= ir_m_r;
			rst_in_m_r <= rst_pin_in;
			rst_in_s_r <= rst_in_m_r;
			xtal_m_r   <= crystal_input_pin;
			xtal_s_r   <= xtal_m_r;
		end
	end

	wire tck_rise = tck_s_r & ~tck_d_r;
	wire tck_fall = ~tck_s_r & tck_d_r;
	wire st_cap   = st_s_r[0];
	wire st_shift = st_s_r[1];
	wire st_upd   = st_s_r[2];
	wire st_tlr   = st_s_r[3];

	wire is_extest = (ir_s_r == `BSR_IR_EXTEST);
	wire is_sample = (ir_s_r == `BSR_IR_SAMPLE);
	wire selected  = is_extest | is_sample;

	// ============================================================
	// Capture vector, laid out over the full large-package map.
	wire [PORT_PINS-1:0] port_in_s;
	wire                 can_rx_in_s;
	wire                 can_tx_in_s;
	reg  [FULL-1:0]      cap_vec;
	integer              g;

	always @*
	begin
		cap_vec = {FULL{1'b0}};
		cap_vec[`BSR_BIT_RST_EN]   = core_rst_drive_en;
		cap_vec[`BSR_BIT_RST_IN]   = rst_in_s_r;
		cap_vec[`BSR_BIT_CAN_RX]   = can_rx_core_oe;
		cap_vec[`BSR_BIT_CAN_RX+1] = can_rx_in_s;
		cap_vec[`BSR_BIT_CAN_TX]   = can_tx_core_oe;
		cap_vec[`BSR_BIT_CAN_TX+1] = can_tx_in_s;
		cap_vec[`BSR_BIT_XTAL]     = xtal_s_r;
		cap_vec[`BSR_BIT_WPU]      = core_weak_pullup_en;
		// Port pins are contiguous pairs from port 0 through port 7.
		for (g = 0; g < PORT_PINS; g = g + 1)
		begin
			cap_vec[`BSR_BIT_PORT0+2*g]   = port_core_oe[g];
			cap_vec[`BSR_BIT_PORT0+2*g+1] = port_in_s[g];
		end
	end

	// ============================================================
	// Shift register: only BSR_LEN stages take part in the path.
	reg [FULL-1:0] sr_r;
	reg [FULL-1:0] sr_nxt;
	integer        i;

	always @*
	begin
		sr_nxt = sr_r;
		if (tck_rise && selected && st_cap)
			sr_nxt = cap_vec;
		else if (tck_rise && selected && st_shift)
		begin
			for (i = 0; i < FULL; i = i + 1)
			begin
				if (i == BSR_LEN - 1)
					sr_nxt[i] = tdi_s_r;
				else if (i < BSR_LEN - 1)
					sr_nxt[i] = sr_r[i+1];
				else
					sr_nxt[i] = 1'b0;
			end
		end
	end

	// ============================================================
	// Update latches, TDO and the fixed-function pins.
	reg [FULL-1:0] upd_r;

	always @(posedge clk)
	begin
		if (reset)
		begin
			sr_r             <= {FULL{1'b0}};
			upd_r            <= {FULL{1'b0}};
			tdo_r            <= 1'b0;
			tdo_oe_n_r       <= 1'b1;
			rst_pin_oe_n_r   <= 1'b1;
			core_rst_in_r    <= 1'b1;
			weak_pullup_en_r <= 1'b0;
			extest_active_r  <= 1'b0;
		end
		else
		begin
			sr_r <= sr_nxt;
			if (st_tlr)
				upd_r <= {FULL{1'b0}};
			else if (tck_fall && st_upd && is_extest)
				upd_r <= sr_r;
			if (tck_fall)
			begin
				tdo_r      <= sr_r[0];
				tdo_oe_n_r <= ~(st_shift & selected);
			end
			extest_active_r  <= is_extest;
			rst_pin_oe_n_r   <= ~(is_extest ? upd_r[`BSR_BIT_RST_EN] : core_rst_drive_en);
			core_rst_in_r    <= is_extest ? 1'b1 : rst_in_s_r;
			weak_pullup_en_r <= is_extest ? upd_r[`BSR_BIT_WPU] : core_weak_pullup_en;
		end
	end

	// ============================================================
	// Pin cells: CAN pins and the port pins.
	bsr_pin_cell u_can_rx
	(
		.clk        (clk),
		.reset      (reset),
		.extest     (is_extest),
		.upd_oe     (upd_r[`BSR_BIT_CAN_RX]),
		.upd_dat    (upd_r[`BSR_BIT_CAN_RX+1]),
		.core_oe    (can_rx_core_oe),
		.core_out   (can_rx_core_out),
		.pin_in     (can_rx_pin_in),
		.pin_in_s   (can_rx_in_s),
		.pin_out_r  (can_rx_pin_out_r),
		.pin_oe_n_r (can_rx_pin_oe_n_r),
		.core_in_r  (can_rx_core_in_r)
	);

	bsr_pin_cell u_can_tx
	(
		.clk        (clk),
		.reset      (reset),
		.extest     (is_extest),
		.upd_oe     (upd_r[`BSR_BIT_CAN_TX]),
		.upd_dat    (upd_r[`BSR_BIT_CAN_TX+1]),
		.core_oe    (can_tx_core_oe),
		.core_out   (can_tx_core_out),
		.pin_in     (can_tx_pin_in),
		.pin_in_s   (can_tx_in_s),
		.pin_out_r  (can_tx_pin_out_r),
		.pin_oe_n_r (can_tx_pin_oe_n_r),
		.core_in_r  (can_tx_core_in_r)
	);

	genvar p;
	generate
		for (p = 0; p < PORT_PINS; p = p + 1)
		begin : g_port
			bsr_pin_cell u_cell
			(
				.clk        (clk),
				.reset      (reset),
				.extest     (is_extest),
				.upd_oe     (upd_r[`BSR_BIT_PORT0+2*p]),
				.upd_dat    (upd_r[`BSR_BIT_PORT0+2*p+1]),
				.core_oe    (port_core_oe[p]),
				.core_out   (port_core_out[p]),
				.pin_in     (port_pin_in[p]),
				.pin_in_s   (port_in_s[p]),
				.pin_out_r  (port_pin_out_r[p]),
				.pin_oe_n_r (port_pin_oe_n_r[p]),
				.core_in_r  (port_core_in_r[p])
			);
		end
	endgenerate

endmodule

// ---- tb/bsr_chk.sv ----
`timescale 1ns/100ps
// ============================================================
// Port checks of the boundary register.
module bsr_chk
#(
	parameter PORT_PINS = 59
)
(
	input wire			clk,
	input wire			reset,
	input wire			tck,
	input wire			tdo_r,
	input wire			tdo_oe_n_r,
	input wire			tap_update_dr,
	input wire			tap_logic_reset,
	input wire [15:0]		tap_ir_code,
	input wire			core_weak_pullup_en,
	input wire			weak_pullup_en_r,
	input wire			core_rst_in_r,
	input wire			extest_active_r,
	input wire [PORT_PINS-1:0]	port_core_oe,
	input wire [PORT_PINS-1:0]	port_pin_out_r,
	input wire [PORT_PINS-1:0]	port_pin_oe_n_r,
	input wire [PORT_PINS-1:0]	port_core_in_r
);
	logic [3:0]	quiet_r;
	logic [3:0]	quiet_nxt;

	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	// Counts clocks since the last update or test-logic reset under external test.
	assign quiet_nxt = (tap_update_dr || tap_logic_reset || tap_ir_code != 16'h0000) ? 4'h0
		: quiet_r + {3'h0, quiet_r != 4'hf};
	always_ff @(posedge clk)
		quiet_r <= reset ? 4'h0 : quiet_nxt;

	sequence s_sample;
		(tap_ir_code == 16'h0002 && $stable(port_core_oe) && $stable(core_weak_pullup_en))[*8];
	endsequence
	sequence s_other;
		(tap_ir_code != 16'h0000 && tap_ir_code != 16'h0002)[*5];
	endsequence

	AST_TDO_IDLE: assert property (s_other |-> tdo_oe_n_r)
		else $error("tdo enabled under another code");
	AST_EXT_ON: assert property ((tap_ir_code == 16'h0000)[*5] |-> extest_active_r)
		else $error("external test not active");
	AST_EXT_OFF: assert property (s_other |-> !extest_active_r)
		else $error("external test active under another code");
	AST_CORE_HIGH: assert property ((extest_active_r && tap_ir_code == 16'h0000)[*3]
		|-> core_rst_in_r && &port_core_in_r) else $error("core inputs not forced high");
	AST_SAMPLE_OE: assert property (s_sample |-> port_pin_oe_n_r == ~port_core_oe)
		else $error("pin enables not functional in sample");
	AST_SAMPLE_WPU: assert property (s_sample |-> weak_pullup_en_r == core_weak_pullup_en)
		else $error("weak pullup not functional in sample");
	AST_TDO_FALL: assert property ($changed(tdo_r) |-> !$past(tck, 2))
		else $error("tdo changed away from a falling test clock");
	AST_HOLD: assert property (quiet_r > 4'h8 |-> $stable(port_pin_out_r)
		&& $stable(port_pin_oe_n_r) && $stable(weak_pullup_en_r)) else $error("latch moved");
	AST_RST_VAL: assert property ($fell(reset) |-> tdo_oe_n_r && &port_pin_oe_n_r
		&& !weak_pullup_en_r) else $error("bad reset values");
	AST_LR_CLEAR: assert property ((tap_logic_reset && extest_active_r)[*6]
		|-> &port_pin_oe_n_r && !(|port_pin_out_r)) else $error("latches not cleared");
endmodule

bind bsr_top bsr_chk #(.PORT_PINS(PORT_PINS)) u_chk (.*);

// ---- tb/bsr_jtag_model.sv ----
`timescale 1ns/100ps
// ============================================================
// Test controller: walks the data-register path; tck idles low between frames.
module bsr_jtag_model
#(
	parameter LEN = 126
)
(
	output logic	tck,
	output logic	tdi,
	output logic	tap_capture_dr,
	output logic	tap_shift_dr,
	output logic	tap_update_dr,
	input wire	tdo_r
);
	initial
		{tck, tdi, tap_capture_dr, tap_shift_dr, tap_update_dr} = 5'h00;

	// Levels change mid-low so they are stable around both edges; tdo is read mid-high.
	task automatic cyc(input logic c, s, u, b, output logic q);
	begin
		#40 {tap_capture_dr, tap_shift_dr, tap_update_dr, tdi} = {c, s, u, b};
		#40 tck = 1'b1;
		#40 q = tdo_r;
		#40 tck = 1'b0;
	end
	endtask

	task automatic scan(input logic [LEN-1:0] din, input logic upd, output logic [LEN-1:0] dout);
		logic	q;
	begin
		cyc(1'b1, 1'b0, 1'b0, 1'b0, q);
		for (int i = 0; i < LEN; i++)
			cyc(1'b0, 1'b1, 1'b0, din[i], dout[i]);
		cyc(1'b0, 1'b0, 1'b0, ~din[LEN-1], q);
		cyc(1'b0, 1'b0, upd, ~din[LEN-1], q);
		#40 {tap_capture_dr, tap_shift_dr, tap_update_dr} = 3'h0;
	end
	endtask
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/100ps
// ============================================================
// Bench for the boundary register.
module tb_top;
	logic		clk, reset, tck, tdi, tdo_r, tdo_oe_n_r, tap_logic_reset, extest_active_r;
	logic		tap_capture_dr, tap_shift_dr, tap_update_dr, crystal_input_pin;
	logic		core_rst_drive_en, rst_pin_in, rst_pin_oe_n_r, core_rst_in_r;
	logic		core_weak_pullup_en, weak_pullup_en_r, can_rx_core_oe, can_rx_core_out;
	logic		can_rx_pin_in, can_rx_pin_out_r, can_rx_pin_oe_n_r, can_rx_core_in_r;
	logic		can_tx_core_oe, can_tx_core_out, can_tx_pin_in, can_tx_pin_out_r;
	logic		can_tx_pin_oe_n_r, can_tx_core_in_r;
	logic [15:0]	tap_ir_code;
	logic [58:0]	port_core_oe, port_core_out, port_pin_in;
	logic [58:0]	port_pin_out_r, port_pin_oe_n_r, port_core_in_r;
	logic [63:0]	w;
	logic [125:0]	u, lu, d, cv;
	logic		tdo_s;
	logic [128:0]	ds;
	logic [185:0]	got;
	int		mismatches, n_compared, cycles;
	logic [23:0]	rows [4] = '{{16'h0000, 8'h3c}, {16'h0004, 8'h0f}, {16'h0000, 8'ha5},
		{16'h0002, 8'h96}};

	assign got = {rst_pin_oe_n_r, core_rst_in_r, weak_pullup_en_r, can_rx_pin_out_r,
		can_rx_pin_oe_n_r, can_rx_core_in_r, can_tx_pin_out_r, can_tx_pin_oe_n_r,
		can_tx_core_in_r, port_pin_out_r, port_pin_oe_n_r, port_core_in_r};

	bsr_top DUT (.*);
	// Small-package register on the same scan stream; only its serial output is watched.
	bsr_top #(.BSR_LEN(118)) DUT_S (.*, .tdo_r(tdo_s), .tdo_oe_n_r(), .rst_pin_oe_n_r(),
		.core_rst_in_r(), .weak_pullup_en_r(), .can_rx_pin_out_r(), .can_rx_pin_oe_n_r(),
		.can_rx_core_in_r(), .can_tx_pin_out_r(), .can_tx_pin_oe_n_r(),
		.can_tx_core_in_r(), .port_pin_out_r(), .port_pin_oe_n_r(), .port_core_in_r(),
		.extest_active_r());

	// Records the small register's serial output at the point where the model reads its own.
	always @(posedge tck)
	begin
		#40 ds = {tdo_s, ds[128:1]};
	end
	bsr_jtag_model m (.*);

	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	task automatic setp(input logic [7:0] p);
	begin
		w = {8{p}};
		{core_weak_pullup_en, crystal_input_pin, can_tx_pin_in, can_tx_core_oe} = p[7:4];
		{can_rx_pin_in, can_rx_core_oe, rst_pin_in, core_rst_drive_en} = p[3:0];
		{can_rx_core_out, can_tx_core_out} = {p[5], p[3]};
		{port_core_oe, port_pin_in, port_core_out} = {w[58:0], ~w[60:2], w[63:5]};
	end
	endtask

	function automatic logic [125:0] capv(input logic [7:0] p);
		logic [125:0]	c;
	begin
		c[7:0] = p;
		for (int g = 0; g < 59; g++)
			{c[9+2*g], c[8+2*g]} = {port_pin_in[g], port_core_oe[g]};
		return c;
	end
	endfunction

	function automatic logic [185:0] pins(input logic e, input logic [125:0] v);
		logic [58:0]	o, n;
	begin
		for (int g = 0; g < 59; g++)
			{o[g], n[g]} = {v[9+2*g], ~v[8+2*g]};
		if (e)
			return {~v[0], 1'b1, v[7], v[3], ~v[2], 1'b1, v[5], ~v[4], 1'b1, o, n, {59{1'b1}}};
		return {~core_rst_drive_en, rst_pin_in, core_weak_pullup_en, can_rx_core_out,
			~can_rx_core_oe, can_rx_pin_in, can_tx_core_out, ~can_tx_core_oe, can_tx_pin_in,
			port_core_out, ~port_core_oe, port_pin_in};
	end
	endfunction

	task automatic cmp_scan(input logic [125:0] g, e);
	begin
		n_compared++;
		if (g !== e)
		begin
			mismatches++;
			$display("Error %0t scan out %h expected %h", $time, g, e);
		end
	end
	endtask

	task automatic cmp_pins(input logic [185:0] g, e);
	begin
		n_compared++;
		if (g !== e)
		begin
			mismatches++;
			$display("Error %0t pins %h expected %h", $time, g, e);
		end
	end
	endtask

	task automatic frame(input logic upd);
	begin
		repeat (4) @(posedge clk);
		#1 m.scan(u, upd, d);
		repeat (8) @(posedge clk);
		#1;
	end
	endtask

	task automatic results();
	begin
		$display("Compared %0d, mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	end
	endtask

	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			mismatches++;
			results();
		end
	end

	initial
	begin
		{reset, tap_logic_reset, tap_ir_code} = {1'b1, 1'b0, 16'hffff};
		setp(8'h00);
		repeat (5) @(posedge clk);
		#1 reset = 1'b0;
		repeat (4) @(posedge clk);
		#1;
		for (int r = 0; r < 4; r++)
		begin
			tap_ir_code = rows[r][23:8];
			setp(rows[r][7:0]);
			u = {w[61:0], ~w};
			frame(1'b1);
			cv = capv(rows[r][7:0]);
			if (tap_ir_code != 16'h0004)
			begin
				cmp_scan(d, cv);
				cmp_scan(ds[126:1], {u[7:0], cv[117:0]});
			end
			cmp_pins(got, pins(tap_ir_code == 16'h0000, u));
			if (tap_ir_code == 16'h0000)
				lu = u;
		end
		tap_ir_code = 16'h0000;
		setp(8'h71);
		frame(1'b0);
		cmp_scan(d, capv(8'h71));
		cmp_pins(got, pins(1'b1, lu));
		tap_logic_reset = 1'b1;
		repeat (8) @(posedge clk);
		#1 cmp_pins(got, pins(1'b1, 126'h0));
		tap_logic_reset = 1'b0;
		frame(1'b1);
		cmp_scan(d, capv(8'h71));
		cmp_pins(got, pins(1'b1, u));
		reset = 1'b1;
		repeat (3) @(posedge clk);
		#1 cmp_pins(got, pins(1'b1, 126'h0));
		reset = 1'b0;
		results();
	end
endmodule
